// File: rtl/pwi_port.sv
// one port's copy of the tag, wake event and interrupt registers
`timescale 1ns/100ps
`default_nettype none
`include "pwi_defs.svh"

module pwi_port #(
  parameter bit HAS_PHY   = 1'b1,
  parameter bit HAS_SGMII = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        wr_stb,
  input  wire logic [11:0] wr_ofs,
  input  wire logic [7:0]  wr_data,
  input  wire logic        magic_hit,
  input  wire logic        link_up_det,
  input  wire logic        energy_det,
  input  wire logic        an_done,
  input  wire logic        phy_irq,
  input  wire logic        acl_irq,
  output logic      [7:0]  tag_hi_img,
  output logic      [7:0]  tag_lo_img,
  output logic      [7:0]  wflag_img,
  output logic      [7:0]  wen_img,
  output logic      [7:0]  stat_img,
  output logic      [7:0]  mask_img,
  output logic             wake_req,
  output logic             int_req
);

  pwi_pkg::pwi_port_st_t q;
  pwi_pkg::pwi_port_st_t d;
  logic [`PWI_WK_W-1:0]  en_ok;

  // link and energy events only exist where a phy is integrated
  assign en_ok = HAS_PHY ? 3'h7 : 3'h4;

  always_comb begin
    d     = q;
    d.an  = HAS_SGMII & an_done;
    d.phy = HAS_PHY & phy_irq;
    if (wr_stb) begin
      case (wr_ofs)
        `PWI_OFS_TAG_HI: begin
          d.tag_hi = wr_data;
        end
        `PWI_OFS_TAG_LO: begin
          d.tag_lo = wr_data;
        end
        `PWI_OFS_WK_FLAG: begin
          d.wflag = q.wflag & ~wr_data[`PWI_WK_W-1:0];
        end
        `PWI_OFS_WK_EN: begin
          d.wen = wr_data[`PWI_WK_W-1:0] & en_ok;
        end
        `PWI_OFS_INT_MASK: begin
          d.mask = wr_data[`PWI_MASK_W-1:0] & `PWI_MASK_RW;
          // a change of the mask bit is the only way to drop the flag
          if (wr_data[`PWI_IS_ACL] != q.mask[`PWI_IS_ACL]) begin
            d.access_list = 1'b0;
          end
        end
        default: begin
          d.tag_hi = q.tag_hi;
        end
      endcase
    end
    // sets come last so an event in the clearing cycle is kept
    if (magic_hit) begin
      d.wflag[`PWI_WK_MAGIC] = 1'b1;
    end
    if (HAS_PHY && link_up_det) begin
      d.wflag[`PWI_WK_LINK] = 1'b1;
    end
    if (HAS_PHY && energy_det) begin
      d.wflag[`PWI_WK_ENERGY] = 1'b1;
    end
    if (acl_irq) begin
      d.access_list = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q        <= '0;
      q.tag_hi <= `PWI_TAG_HI_RST;
      q.tag_lo <= `PWI_TAG_LO_RST;
    end else begin
      q <= d;
    end
  end

  assign tag_hi_img = q.tag_hi;
  assign tag_lo_img = q.tag_lo;
  assign wflag_img  = {5'h00, q.wflag};
  assign wen_img    = {5'h00, q.wen};
  assign stat_img   = {4'h0, q.an, 1'b0, q.phy, q.access_list};
  assign mask_img   = {4'h0, q.mask};
  assign wake_req   = |(q.wflag & q.wen);
  assign int_req    = |(stat_img[`PWI_MASK_W-1:0] & ~q.mask);

endmodule
`default_nettype wire

// File: rtl/pwi_regs.sv
// per-port default tag, wake event and port interrupt register set
// What this block does
// - one register copy per port, port chosen by upper address digit, ports 1-7
// - tag high byte holds pcp, dei and vid 11:8, reset 0x00
// - tag low byte holds vid 7:0, read/write, reset 0x01
// - wake packet counts only if its destination equals the switch mac
// - wake packet flag bit 2 sets on detection, write-one clears it
// - link-up flag bit 1 sets on phy ports, cleared by write
// - energy flag bit 0 sets on phy ports, cleared by write
// - wake packet drives the wake output only while enable bit 2 is set
// - link-up drives the wake output only while enable bit 1 is set
// - energy drives the wake output only while enable bit 0 is set
// - status bit 3 shows sgmii negotiation done, port 7 only, read-only
// - status bit 1 summarises phy interrupts on phy ports, read-only
// - status bit 0 sets on an access-list counter interrupt, every port
// - access-list status clears when its mask bit is toggled
// - mask bits 3,1,0 gate status; zero enables; reset zero
`timescale 1ns/100ps
`default_nettype none
`include "pwi_defs.svh"

module pwi_regs #(
  parameter int              NUM_PORTS = `PWI_NPORT,
  parameter logic [`PWI_NPORT-1:0] PHY_PORTS = `PWI_PHY_PORTS
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic [15:0]           reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic [`PWI_MAC_W-1:0] switch_mac,
  input  wire logic [NUM_PORTS-1:0]  magic_seen,
  input  wire logic [`PWI_MAC_W-1:0] magic_da [NUM_PORTS],
  input  wire logic [NUM_PORTS-1:0]  link_up_det,
  input  wire logic [NUM_PORTS-1:0]  energy_det,
  input  wire logic                  an_done,
  input  wire logic [NUM_PORTS-1:0]  phy_irq,
  input  wire logic [NUM_PORTS-1:0]  acl_irq,
  output logic                       wake_event_output,
  output logic      [NUM_PORTS-1:0]  port_irq
);

  // the state struct is sized by the header, so the count is fixed
  if (NUM_PORTS != `PWI_NPORT) begin : g_bad_ports
    $error("pwi_regs: NUM_PORTS must match the register map");
  end

  pwi_pkg::pwi_top_st_t q;
  pwi_pkg::pwi_top_st_t d;

  logic [3:0]           port_sel;
  logic [11:0]          ofs;
  logic                 port_ok;
  logic [NUM_PORTS-1:0] wr_stb;
  logic [NUM_PORTS-1:0] magic_hit;
  logic [NUM_PORTS-1:0] wake_req;
  logic [NUM_PORTS-1:0] int_req;
  logic [7:0]           tag_hi_img [NUM_PORTS];
  logic [7:0]           tag_lo_img [NUM_PORTS];
  logic [7:0]           wflag_img  [NUM_PORTS];
  logic [7:0]           wen_img    [NUM_PORTS];
  logic [7:0]           stat_img   [NUM_PORTS];
  logic [7:0]           mask_img   [NUM_PORTS];

  assign port_sel = reg_addr[15:12];
  assign ofs      = reg_addr[11:0];
  assign port_ok  = (port_sel >= `PWI_PORT_FIRST) &&
                    (port_sel <= `PWI_PORT_LAST);

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    // port numbers start at one, array index at zero
    assign wr_stb[i]    = reg_wr && port_ok &&
                          (port_sel == 4'(i + 1));
    assign magic_hit[i] = magic_seen[i] &&
                          (magic_da[i] == switch_mac);

    pwi_port #(
      .HAS_PHY   (PHY_PORTS[i]),
      .HAS_SGMII (4'(i + 1) == `PWI_SGMII_PORT)
    ) u_port (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .wr_stb      (wr_stb[i]),
      .wr_ofs      (ofs),
      .wr_data     (reg_wdata),
      .magic_hit   (magic_hit[i]),
      .link_up_det (link_up_det[i]),
      .energy_det  (energy_det[i]),
      .an_done     (an_done),
      .phy_irq     (phy_irq[i]),
      .acl_irq     (acl_irq[i]),
      .tag_hi_img  (tag_hi_img[i]),
      .tag_lo_img  (tag_lo_img[i]),
      .wflag_img   (wflag_img[i]),
      .wen_img     (wen_img[i]),
      .stat_img    (stat_img[i]),
      .mask_img    (mask_img[i]),
      .wake_req    (wake_req[i]),
      .int_req     (int_req[i])
    );
  end

  // read data is registered; unmapped offsets and ports read as zero
  always_comb begin
    d        = q;
    d.rvalid = reg_rd;
    d.rdata  = 8'h00;
    if (reg_rd && port_ok) begin
      for (int k = 0; k < NUM_PORTS; k++) begin
        if (port_sel == 4'(k + 1)) begin
          case (ofs)
            `PWI_OFS_TAG_HI:   d.rdata = tag_hi_img[k];
            `PWI_OFS_TAG_LO:   d.rdata = tag_lo_img[k];
            `PWI_OFS_WK_FLAG:  d.rdata = wflag_img[k];
            `PWI_OFS_WK_EN:    d.rdata = wen_img[k];
            `PWI_OFS_INT_STAT: d.rdata = stat_img[k];
            `PWI_OFS_INT_MASK: d.rdata = mask_img[k];
            default:           d.rdata = 8'h00;
          endcase
        end
      end
    end
    d.wake = |wake_req;
    d.irq  = int_req;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata         = q.rdata;
  assign reg_rvalid        = q.rvalid;
  assign wake_event_output = q.wake;
  assign port_irq          = q.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // wake pin drops one cycle after the last enabled flag is gone
  property p_wake_quiet;
    (wake_req == '0) |=> !wake_event_output;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet)
    else $error("wake output high with no enabled flag");

  property p_bad_port_write;
    (reg_wr && !port_ok) |=> $stable(tag_lo_img[0]) && ($stable(wflag_img[0])
      || $past(magic_hit[0] || link_up_det[0] || energy_det[0]));
  endproperty
  a_bad_port_write: assert property (p_bad_port_write)
    else $error("write to invalid port changed port 1");

  property p_unmapped_read;
    (reg_rd && !port_ok) |=> reg_rvalid && reg_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("read of invalid port not zero");

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_chk
    property p_tag_reset;
      $rose(rst_b) |-> tag_hi_img[i] == `PWI_TAG_HI_RST &&
                       tag_lo_img[i] == `PWI_TAG_LO_RST;
    endproperty
    a_tag_reset: assert property (p_tag_reset)
      else $error("default tag reset value wrong");

    property p_tag_write;
      (wr_stb[i] && ofs == `PWI_OFS_TAG_HI) |=>
        tag_hi_img[i] == $past(reg_wdata);
    endproperty
    a_tag_write: assert property (p_tag_write)
      else $error("tag high byte not written");

    property p_magic_set;
      magic_hit[i] |=> wflag_img[i][`PWI_WK_MAGIC];
    endproperty
    a_magic_set: assert property (p_magic_set)
      else $error("wake packet flag not set");

    property p_magic_match;
      (magic_seen[i] && magic_da[i] != switch_mac &&
       !wflag_img[i][`PWI_WK_MAGIC]) |=> !wflag_img[i][`PWI_WK_MAGIC];
    endproperty
    a_magic_match: assert property (p_magic_match)
      else $error("flag set by foreign address");

    property p_magic_clear;
      (wr_stb[i] && ofs == `PWI_OFS_WK_FLAG &&
       reg_wdata[`PWI_WK_MAGIC] && !magic_hit[i])
        |=> !wflag_img[i][`PWI_WK_MAGIC];
    endproperty
    a_magic_clear: assert property (p_magic_clear)
      else $error("wake packet flag not cleared by write");

    property p_magic_hold;
      (wflag_img[i][`PWI_WK_MAGIC] && !(wr_stb[i] &&
       ofs == `PWI_OFS_WK_FLAG && reg_wdata[`PWI_WK_MAGIC]))
        |=> wflag_img[i][`PWI_WK_MAGIC];
    endproperty
    a_magic_hold: assert property (p_magic_hold)
      else $error("wake packet flag dropped by itself");

    property p_wake_pin;
      (|(wflag_img[i] & wen_img[i])) |=> wake_event_output;
    endproperty
    a_wake_pin: assert property (p_wake_pin)
      else $error("enabled flag did not raise wake output");

    property p_no_phy_events;
      !PHY_PORTS[i] |-> wflag_img[i][1:0] == 2'h0 && !stat_img[i][1];
    endproperty
    a_no_phy_events: assert property (p_no_phy_events)
      else $error("phy event on a port without phy");

    property p_an_port;
      (4'(i + 1) != `PWI_SGMII_PORT) |-> !stat_img[i][`PWI_IS_AN];
    endproperty
    a_an_port: assert property (p_an_port)
      else $error("negotiation status on wrong port");

    property p_acl_set;
      acl_irq[i] |=> stat_img[i][`PWI_IS_ACL] [*1];
    endproperty
    a_acl_set: assert property (p_acl_set)
      else $error("access-list status not set");

    property p_acl_toggle;
      (wr_stb[i] && ofs == `PWI_OFS_INT_MASK && !acl_irq[i] &&
       reg_wdata[`PWI_IS_ACL] != mask_img[i][`PWI_IS_ACL])
        |=> !stat_img[i][`PWI_IS_ACL];
    endproperty
    a_acl_toggle: assert property (p_acl_toggle)
      else $error("mask toggle did not clear access-list status");

    property p_acl_keep;
      (stat_img[i][`PWI_IS_ACL] && !(wr_stb[i] &&
       ofs == `PWI_OFS_INT_MASK &&
       reg_wdata[`PWI_IS_ACL] != mask_img[i][`PWI_IS_ACL]))
        |=> stat_img[i][`PWI_IS_ACL];
    endproperty
    a_acl_keep: assert property (p_acl_keep)
      else $error("access-list status cleared without toggle");

    property p_irq_gate;
      (|(stat_img[i][3:0] & ~mask_img[i][3:0])) |=> port_irq[i];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
      else $error("enabled status did not raise port request");

    property p_irq_masked;
      ((stat_img[i][3:0] & ~mask_img[i][3:0]) == 4'h0) |=> !port_irq[i];
    endproperty
    a_irq_masked: assert property (p_irq_masked)
      else $error("masked status raised port request");
  end

  property p_read_lo;
    (reg_rd && !reg_wr && ofs == `PWI_OFS_TAG_LO &&
     port_sel == `PWI_PORT_FIRST)
      |=> reg_rvalid && reg_rdata == tag_lo_img[0];
  endproperty
  a_read_lo: assert property (p_read_lo)
    else $error("tag low read data wrong");

  c_wake: cover property (magic_hit[0] ##1 wen_img[0][`PWI_WK_MAGIC]
                          ##2 wake_event_output);
  c_acl_clear: cover property (stat_img[0][`PWI_IS_ACL] ##1
                               !stat_img[0][`PWI_IS_ACL]);
  c_read: cover property (reg_rd && port_sel == `PWI_PORT_LAST ##1
                          reg_rvalid);
  c_set_clear: cover property (magic_hit[1] && wr_stb[1] &&
                               ofs == `PWI_OFS_WK_FLAG);

endmodule
`default_nettype wire

// File: shared/pwi_defs.svh
// offsets, field positions, reset values and sizes of the port register set
`ifndef PWI_DEFS_SVH
`define PWI_DEFS_SVH

`define PWI_NPORT        7
`define PWI_PORT_FIRST   4'h1
`define PWI_PORT_LAST    4'h7
`define PWI_SGMII_PORT   4'h7
`define PWI_PHY_PORTS    7'h1F

`define PWI_OFS_TAG_HI   12'h000
`define PWI_OFS_TAG_LO   12'h001
`define PWI_OFS_WK_FLAG  12'h013
`define PWI_OFS_WK_EN    12'h017
`define PWI_OFS_INT_STAT 12'h01B
`define PWI_OFS_INT_MASK 12'h01F

`define PWI_TAG_HI_RST   8'h00
`define PWI_TAG_LO_RST   8'h01

`define PWI_WK_MAGIC     2
`define PWI_WK_LINK      1
`define PWI_WK_ENERGY    0
`define PWI_WK_W         3

`define PWI_IS_AN        3
`define PWI_IS_PHY       1
`define PWI_IS_ACL       0
`define PWI_MASK_W       4
`define PWI_MASK_RW      4'hB

`define PWI_MAC_W        48

`endif

// File: shared/pwi_pkg.sv
// state types of the port wake and interrupt register set
`default_nettype none
`include "pwi_defs.svh"

package pwi_pkg;

  typedef struct packed {
    logic [7:0]               tag_hi;
    logic [7:0]               tag_lo;
    logic [`PWI_WK_W-1:0]     wflag;
    logic [`PWI_WK_W-1:0]     wen;
    logic [`PWI_MASK_W-1:0]   mask;
    logic                     an;
    logic                     phy;
    logic                     access_list;
  } pwi_port_st_t;

  typedef struct packed {
    logic [7:0]               rdata;
    logic                     rvalid;
    logic                     wake;
    logic [`PWI_NPORT-1:0]    irq;
  } pwi_top_st_t;

endpackage
`default_nettype wire

// File: tb/pwi_evt_src.sv
// partner model: port-side detectors feeding the register set
`timescale 1ns/100ps
`default_nettype none
`include "pwi_defs.svh"

module pwi_evt_src (
  input  wire logic                  sys_clk,
  output logic      [`PWI_MAC_W-1:0] switch_mac,
  output logic      [6:0]            magic_seen,
  output logic      [`PWI_MAC_W-1:0] magic_da [7],
  output logic      [6:0]            link_up_det,
  output logic      [6:0]            energy_det,
  output logic                       an_done,
  output logic      [6:0]            phy_irq,
  output logic      [6:0]            acl_irq
);
  // arbitrary station address
  localparam logic [47:0] MAC = 48'h02AB_CDEF_0123;

  initial begin
    switch_mac = MAC;
    magic_seen = 7'h00;
    link_up_det = 7'h00;
    energy_det = 7'h00;
    acl_irq = 7'h00;
    phy_irq = 7'h00;
    an_done = 1'b0;
    for (int i = 0; i < 7; i++) begin
      magic_da[i] = ~MAC;
    end
  end

  // k: 0 packet, 1 link, 2 energy, 3 access list (pulses); 4 phy, 5 an (level)
  task automatic ev(input int k, input int p, input logic v);
    @(negedge sys_clk);
    case (k)
      0: begin
        magic_da[p-1] = v ? MAC : ~MAC;
        magic_seen[p-1] = 1'b1;
      end
      1: link_up_det[p-1] = 1'b1;
      2: energy_det[p-1] = 1'b1;
      3: acl_irq[p-1] = 1'b1;
      4: phy_irq[p-1] = v;
      default: an_done = v;
    endcase
    @(negedge sys_clk);
    magic_seen = 7'h00;
    link_up_det = 7'h00;
    energy_det = 7'h00;
    acl_irq = 7'h00;
    // a released address bus must not keep showing a match
    if (k == 0) begin
      magic_da[p-1] = ~MAC;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the port wake and interrupt register set
`timescale 1ns/100ps
`default_nettype none
`include "pwi_defs.svh"

module testbench;
  logic        sys_clk;
  logic        rst_b;
  logic [15:0] reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [47:0] switch_mac;
  logic [6:0]  magic_seen;
  logic [47:0] magic_da [7];
  logic [6:0]  link_up_det;
  logic [6:0]  energy_det;
  logic        an_done;
  logic [6:0]  phy_irq;
  logic [6:0]  acl_irq;
  logic        wake_event_output;
  logic [6:0]  port_irq;
  int          bad_count;
  int          tests_run;

  pwi_regs pwi_regs_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .switch_mac(switch_mac), .magic_seen(magic_seen),
    .magic_da(magic_da), .link_up_det(link_up_det),
    .energy_det(energy_det), .an_done(an_done), .phy_irq(phy_irq),
    .acl_irq(acl_irq), .wake_event_output(wake_event_output),
    .port_irq(port_irq)
  );

  pwi_evt_src pwi_evt_src_i (
    .sys_clk(sys_clk), .switch_mac(switch_mac),
    .magic_seen(magic_seen), .magic_da(magic_da),
    .link_up_det(link_up_det), .energy_det(energy_det),
    .an_done(an_done), .phy_irq(phy_irq), .acl_irq(acl_irq)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] ad(input int p, input logic [11:0] o);
    return {p[3:0], o};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // read data stands for one cycle only, so it is caught on that cycle
  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [7:0] e);
    int i;
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge sys_clk);
    if (i == 4) begin
      bad_count++;
      $display("ERROR rvalid expected 1 seen %b", reg_rvalid);
      summarize();
    end else begin
      chk(nm, reg_rdata, e);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_b = 1'b0;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    for (int p = 1; p <= 7; p++) begin
      rd_chk("tag_hi", ad(p, `PWI_OFS_TAG_HI), `PWI_TAG_HI_RST);
      rd_chk("tag_lo", ad(p, `PWI_OFS_TAG_LO), `PWI_TAG_LO_RST);
      rd_chk("mask", ad(p, `PWI_OFS_INT_MASK), 8'h00);
      rd_chk("wk_flag", ad(p, `PWI_OFS_WK_FLAG), 8'h00);
      rd_chk("wk_en", ad(p, `PWI_OFS_WK_EN), 8'h00);
      rd_chk("status", ad(p, `PWI_OFS_INT_STAT), 8'h00);
    end
    $display("test reset values done");
    for (int p = 1; p <= 7; p++) begin
      wr(ad(p, `PWI_OFS_TAG_HI), 8'hB0 + 8'(p));
      wr(ad(p, `PWI_OFS_TAG_LO), 8'h10 + 8'(p));
    end
    wr(ad(0, `PWI_OFS_TAG_LO), 8'h55);
    wr(ad(8, `PWI_OFS_TAG_LO), 8'h55);
    for (int p = 1; p <= 7; p++) begin
      rd_chk("tag_hi", ad(p, `PWI_OFS_TAG_HI), 8'hB0 + 8'(p));
      rd_chk("tag_lo", ad(p, `PWI_OFS_TAG_LO), 8'h10 + 8'(p));
    end
    rd_chk("port0", ad(0, `PWI_OFS_TAG_LO), 8'h00);
    rd_chk("port8", ad(8, `PWI_OFS_TAG_LO), 8'h00);
    $display("test per-port tags done");
    pwi_evt_src_i.ev(0, 1, 1'b0);
    rd_chk("wk_flag", ad(1, `PWI_OFS_WK_FLAG), 8'h00);
    pwi_evt_src_i.ev(0, 1, 1'b1);
    idle(2);
    chk("wake", {7'h00, wake_event_output}, 8'h00);
    rd_chk("wk_flag", ad(1, `PWI_OFS_WK_FLAG), 8'h04);
    wr(ad(1, `PWI_OFS_WK_EN), 8'h04);
    idle(2);
    chk("wake", {7'h00, wake_event_output}, 8'h01);
    wr(ad(1, `PWI_OFS_WK_FLAG), 8'h04);
    idle(2);
    chk("wake", {7'h00, wake_event_output}, 8'h00);
    rd_chk("wk_flag", ad(1, `PWI_OFS_WK_FLAG), 8'h00);
    pwi_evt_src_i.ev(1, 1, 1'b1);
    pwi_evt_src_i.ev(2, 1, 1'b1);
    idle(2);
    chk("wake", {7'h00, wake_event_output}, 8'h00);
    rd_chk("wk_flag", ad(1, `PWI_OFS_WK_FLAG), 8'h03);
    wr(ad(1, `PWI_OFS_WK_EN), 8'h02);
    idle(2);
    chk("wake", {7'h00, wake_event_output}, 8'h01);
    wr(ad(1, `PWI_OFS_WK_FLAG), 8'h02);
    idle(2);
    chk("wake", {7'h00, wake_event_output}, 8'h00);
    rd_chk("wk_flag", ad(1, `PWI_OFS_WK_FLAG), 8'h01);
    wr(ad(1, `PWI_OFS_WK_EN), 8'h01);
    idle(2);
    chk("wake", {7'h00, wake_event_output}, 8'h01);
    wr(ad(1, `PWI_OFS_WK_FLAG), 8'h01);
    rd_chk("wk_flag", ad(1, `PWI_OFS_WK_FLAG), 8'h00);
    pwi_evt_src_i.ev(1, 6, 1'b1);
    pwi_evt_src_i.ev(2, 6, 1'b1);
    rd_chk("wk_flag6", ad(6, `PWI_OFS_WK_FLAG), 8'h00);
    wr(ad(6, `PWI_OFS_WK_EN), 8'hFF);
    rd_chk("wk_en6", ad(6, `PWI_OFS_WK_EN), 8'h04);
    // event and clear land on the same edge: the event must survive
    fork
      wr(ad(2, `PWI_OFS_WK_FLAG), 8'h04);
      pwi_evt_src_i.ev(0, 2, 1'b1);
    join
    rd_chk("wk_flag2", ad(2, `PWI_OFS_WK_FLAG), 8'h04);
    $display("test wake events done");
    pwi_evt_src_i.ev(3, 2, 1'b1);
    idle(2);
    chk("irq", {1'b0, port_irq}, 8'h02);
    rd_chk("status", ad(2, `PWI_OFS_INT_STAT), 8'h01);
    wr(ad(2, `PWI_OFS_INT_STAT), 8'hFF);
    rd_chk("status", ad(2, `PWI_OFS_INT_STAT), 8'h01);
    wr(ad(2, `PWI_OFS_INT_MASK), 8'h01);
    rd_chk("status", ad(2, `PWI_OFS_INT_STAT), 8'h00);
    chk("irq", {1'b0, port_irq}, 8'h00);
    wr(ad(2, `PWI_OFS_INT_MASK), 8'h00);
    pwi_evt_src_i.ev(4, 3, 1'b1);
    idle(2);
    chk("irq", {1'b0, port_irq}, 8'h04);
    rd_chk("status", ad(3, `PWI_OFS_INT_STAT), 8'h02);
    wr(ad(3, `PWI_OFS_INT_MASK), 8'h02);
    idle(2);
    chk("irq", {1'b0, port_irq}, 8'h00);
    rd_chk("status", ad(3, `PWI_OFS_INT_STAT), 8'h02);
    pwi_evt_src_i.ev(4, 3, 1'b0);
    pwi_evt_src_i.ev(5, 7, 1'b1);
    idle(2);
    chk("irq", {1'b0, port_irq}, 8'h40);
    rd_chk("status7", ad(7, `PWI_OFS_INT_STAT), 8'h08);
    rd_chk("status1", ad(1, `PWI_OFS_INT_STAT), 8'h00);
    wr(ad(7, `PWI_OFS_INT_MASK), 8'hFF);
    idle(2);
    chk("irq", {1'b0, port_irq}, 8'h00);
    rd_chk("mask7", ad(7, `PWI_OFS_INT_MASK), 8'h0B);
    pwi_evt_src_i.ev(5, 7, 1'b0);
    $display("test interrupt status done");
    @(negedge sys_clk);
    rst_b = 1'b0;
    idle(2);
    rst_b = 1'b1;
    rd_chk("tag_lo_rst", ad(1, `PWI_OFS_TAG_LO), `PWI_TAG_LO_RST);
    rd_chk("wk_flag_rst", ad(2, `PWI_OFS_WK_FLAG), 8'h00);
    rd_chk("mask_rst", ad(7, `PWI_OFS_INT_MASK), 8'h00);
    $display("test mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
